// ===== src/adcs_consts.vh
// Contract
// - All pairs single-ended, codes 0000 to 0111 route inputs zero to seven.
// - Any code with its top bit set selects the temperature sensor.
// - A differential pair's even code selects it, even input +, odd input -.
// - The pairs 0/1, 2/3, 4/5 and 6/7 are each configured on their own.
// - Config bits 7:3 hold the clock period field and bits 2:0 the gain code.
// - Period field N above zero gives a SAR clock of system clock / (2(N+1)).
// - Reset loads the config register with 11111000.
// - A period field of zero makes the SAR clock the system clock.
// - Gain 000 is 1, 001 is 2, 010 is 4, 011 is 8, 10x is 1 and 11x is 0.5.
// - A pair bit of zero keeps both inputs single-ended, one pairs them.
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH

// Reset values of the three registers.
`define ADCS_CHAN_SEL_RESET 8'h00
`define ADCS_PAIR_CFG_RESET 8'h00
`define ADCS_CLK_GAIN_RESET 8'hF8

// Field positions.
`define ADCS_ADDR_MSB 3
`define ADCS_ADDR_LSB 0
`define ADCS_PAIR_MSB 3
`define ADCS_PAIR_LSB 0
`define ADCS_PERIOD_MSB 7
`define ADCS_PERIOD_LSB 3
`define ADCS_GAIN_MSB 2
`define ADCS_GAIN_LSB 0

// Multiplexer code that stands for the temperature sensor.
`define ADCS_TEMP_SEL 4'h8

// Decoded gain selects, log2 of gain plus one.
`define ADCS_GSEL_HALF 3'h0
`define ADCS_GSEL_X1 3'h1
`define ADCS_GSEL_X2 3'h2
`define ADCS_GSEL_X4 3'h3
`define ADCS_GSEL_X8 3'h4

// Rates in hertz and the smallest period field that keeps the limit.
`define ADCS_SYS_HZ 40000000
`define ADCS_SAR_MAX_HZ 2500000
`define ADCS_MIN_PERIOD ((`ADCS_SYS_HZ + 2 * `ADCS_SAR_MAX_HZ - 1) / (2 * `ADCS_SAR_MAX_HZ) - 1)

`endif

// ===== src/adcs_sar_clk_div.v
`timescale 1ns/1ps
`default_nettype none
module adcs_sar_clk_div #(
    parameter PERIOD_W = 5
) (
    // Clock and reset.
    input wire core_clk_i,
    input wire rst_b_i,
    // Divider control.
    input wire [PERIOD_W-1:0] period_i,
    input wire restart_i,
    // Conversion clock view.
    output reg sar_clk_o,
    output reg sar_clk_en_o
);

reg [PERIOD_W-1:0] cnt;

////////////////////////////////////////////////////////////////////////////
// Half period is period plus one cycles, so the full period is 2(N+1).
// The enable pulses once per conversion clock, at its rising edge.
always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        cnt <= {PERIOD_W{1'b0}};
        sar_clk_o <= 1'b0;
        sar_clk_en_o <= 1'b0;
    end else if (restart_i) begin
        // A new divisor starts a clean low half period.
        cnt <= {PERIOD_W{1'b0}};
        sar_clk_o <= 1'b0;
        sar_clk_en_o <= 1'b0;
    end else if (period_i == {PERIOD_W{1'b0}}) begin
        // Undivided: every system clock is a conversion clock.
        cnt <= {PERIOD_W{1'b0}};
        sar_clk_o <= ~sar_clk_o;
        sar_clk_en_o <= 1'b1;
    end else if (cnt == period_i) begin
        cnt <= {PERIOD_W{1'b0}};
        sar_clk_o <= ~sar_clk_o;
        sar_clk_en_o <= ~sar_clk_o;
    end else begin
        cnt <= cnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
        sar_clk_en_o <= 1'b0;
    end
end

endmodule // adcs_sar_clk_div
`default_nettype wire

// ===== src/adcs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.vh"
module adcs_top (
    // Clock and reset.
    input wire core_clk_i,
    input wire rst_b_i,
    // Register write strobes and shared write data.
    input wire chan_sel_wr_i,
    input wire pair_cfg_wr_i,
    input wire clk_gain_wr_i,
    input wire [7:0] sfr_wdata_i,
    // Register read values.
    output wire [7:0] mux_channel_select_o,
    output wire [7:0] input_pair_config_o,
    output wire [7:0] converter_clock_gain_config_o,
    // Multiplexer steering.
    output reg [3:0] mux_pos_sel_o,
    output reg [2:0] mux_neg_sel_o,
    output reg mux_diff_o,
    output reg mux_temp_o,
    // Amplifier and conversion clock.
    output reg [2:0] pga_gain_sel_o,
    output wire sar_clk_o,
    output wire sar_clk_en_o,
    output reg sar_rate_high_o
);

reg [3:0] mux_address_field;
reg [3:0] input_pair_config;
reg [4:0] sar_clock_period_field;
reg [2:0] amplifier_gain_code;

// Reset images of the registers at full eight-bit width; each field is sliced out where it loads.
localparam [7:0] CHAN_RST = `ADCS_CHAN_SEL_RESET;
localparam [7:0] PAIR_RST = `ADCS_PAIR_CFG_RESET;
localparam [7:0] CFG_RST = `ADCS_CLK_GAIN_RESET;

////////////////////////////////////////////////////////////////////////////
// Decode functions.

// Maps the gain code onto a log2-plus-one select.
function [2:0] gain_sel;
    input [2:0] code;
    begin
        case (code)
            3'h0: gain_sel = `ADCS_GSEL_X1;
            3'h1: gain_sel = `ADCS_GSEL_X2;
            3'h2: gain_sel = `ADCS_GSEL_X4;
            3'h3: gain_sel = `ADCS_GSEL_X8;
            3'h4: gain_sel = `ADCS_GSEL_X1;
            3'h5: gain_sel = `ADCS_GSEL_X1;
            default: gain_sel = `ADCS_GSEL_HALF;
        endcase
    end
endfunction

// Tells whether the pair that holds this input is differential.
function pair_is_diff;
    input [2:0] idx;
    input [3:0] pairs;
    begin
        pair_is_diff = pairs[idx[2:1]];
    end
endfunction

// Positive input select; the temperature sensor wins over everything.
function [3:0] pos_sel;
    input [3:0] addr;
    input [3:0] pairs;
    begin
        if (addr[3]) begin
            pos_sel = `ADCS_TEMP_SEL;
        end else if (pair_is_diff(addr[2:0], pairs)) begin
            // Either code of a differential pair gives the even input.
            pos_sel = {1'b0, addr[2:1], 1'b0};
        end else begin
            pos_sel = {1'b0, addr[2:0]};
        end
    end
endfunction

// Tells whether the code selects a differential pair and not the sensor.
function diff_sel;
    input [3:0] addr;
    input [3:0] pairs;
    begin
        diff_sel = ~addr[3] & pair_is_diff(addr[2:0], pairs);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Channel select register; upper bits hold nothing.
always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        mux_address_field <= CHAN_RST[`ADCS_ADDR_MSB:`ADCS_ADDR_LSB];
    end else if (chan_sel_wr_i) begin
        mux_address_field <=
            sfr_wdata_i[`ADCS_ADDR_MSB:`ADCS_ADDR_LSB];
    end
end

// Input pair configuration register, one bit per pair.
always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        input_pair_config <= PAIR_RST[`ADCS_PAIR_MSB:`ADCS_PAIR_LSB];
    end else if (pair_cfg_wr_i) begin
        input_pair_config <=
            sfr_wdata_i[`ADCS_PAIR_MSB:`ADCS_PAIR_LSB];
    end
end

// Clock and gain configuration register.
always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        sar_clock_period_field <=
            CFG_RST[`ADCS_PERIOD_MSB:`ADCS_PERIOD_LSB];
        amplifier_gain_code <=
            CFG_RST[`ADCS_GAIN_MSB:`ADCS_GAIN_LSB];
    end else if (clk_gain_wr_i) begin
        sar_clock_period_field <=
            sfr_wdata_i[`ADCS_PERIOD_MSB:`ADCS_PERIOD_LSB];
        amplifier_gain_code <=
            sfr_wdata_i[`ADCS_GAIN_MSB:`ADCS_GAIN_LSB];
    end
end

// Read values; unused bits read as zero.
assign mux_channel_select_o = {4'h0, mux_address_field};
assign input_pair_config_o = {4'h0, input_pair_config};
assign converter_clock_gain_config_o =
    {sar_clock_period_field, amplifier_gain_code};

////////////////////////////////////////////////////////////////////////////
// Registered steering to the multiplexer and amplifier, one cycle behind
// the registers so the analogue side sees glitch-free selects.
always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        mux_pos_sel_o <= 4'h0;
        mux_neg_sel_o <= 3'h0;
        mux_diff_o <= 1'b0;
        mux_temp_o <= 1'b0;
        pga_gain_sel_o <= `ADCS_GSEL_X1;
        sar_rate_high_o <= 1'b0;
    end else begin
        mux_pos_sel_o <= pos_sel(mux_address_field, input_pair_config);
        mux_temp_o <= mux_address_field[3];
        mux_diff_o <= diff_sel(mux_address_field, input_pair_config);
        // Negative side is the odd input of the pair; zero otherwise.
        if (diff_sel(mux_address_field, input_pair_config)) begin
            mux_neg_sel_o <= {mux_address_field[2:1], 1'b1};
        end else begin
            mux_neg_sel_o <= 3'h0;
        end
        pga_gain_sel_o <= gain_sel(amplifier_gain_code);
        // Flags a divisor that runs the conversion clock above its limit.
        sar_rate_high_o <= (sar_clock_period_field < `ADCS_MIN_PERIOD);
    end
end

////////////////////////////////////////////////////////////////////////////
// Conversion clock divider, restarted by every clock and gain configuration write.
adcs_sar_clk_div #(
    .PERIOD_W(5)
) u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .period_i(sar_clock_period_field),
    .restart_i(clk_gain_wr_i),
    .sar_clk_o(sar_clk_o),
    .sar_clk_en_o(sar_clk_en_o)
);

endmodule // adcs_top
`default_nettype wire

// ===== tb/adcs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_assertions (
    // Clock, reset and writes.
    input wire core_clk_i,
    input wire rst_b_i,
    input wire clk_gain_wr_i,
    input wire [7:0] sfr_wdata_i,
    // Watched outputs.
    input wire [7:0] mux_channel_select_o,
    input wire [7:0] input_pair_config_o,
    input wire [7:0] converter_clock_gain_config_o,
    input wire [3:0] mux_pos_sel_o,
    input wire [2:0] mux_neg_sel_o,
    input wire mux_diff_o,
    input wire mux_temp_o,
    input wire [2:0] pga_gain_sel_o,
    input wire sar_clk_en_o
);
    logic [3:0] cs, pc;
    logic [2:0] cg;
    logic [6:0] gap;
    logic seen;
    wire [4:0] per = converter_clock_gain_config_o[7:3];
    wire pb = pc[cs[2:1]];
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Registers as the steering saw them, and cycles between ticks.
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {cs, pc, cg, gap, seen} <= 19'h0;
        end else begin
            cs <= mux_channel_select_o[3:0];
            pc <= input_pair_config_o[3:0];
            cg <= converter_clock_gain_config_o[2:0];
            seen <= !clk_gain_wr_i && (seen || sar_clk_en_o);
            gap <= (clk_gain_wr_i || sar_clk_en_o) ? 7'h00 : gap + 7'h01;
        end
    end
    upper_zero_a: assert property (mux_channel_select_o[7:4] == 4'h0)
        else $error("upper bits set");
    cfg_write_a: assert property (clk_gain_wr_i |=>
        converter_clock_gain_config_o == $past(sfr_wdata_i))
        else $error("config write lost");
    temp_sel_a: assert property (cs[3] |-> mux_temp_o &&
        !mux_diff_o && mux_pos_sel_o == 4'h8)
        else $error("temp not selected");
    single_sel_a: assert property (!cs[3] && !pb |->
        !mux_diff_o && mux_pos_sel_o == {1'b0, cs[2:0]})
        else $error("bad single input");
    diff_sel_a: assert property (!cs[3] && pb |-> mux_diff_o &&
        mux_neg_sel_o == {cs[2:1], 1'b1} &&
        mux_pos_sel_o == {1'b0, cs[2:1], 1'b0})
        else $error("bad pair");
    gain_map_a: assert property
        (pga_gain_sel_o == (cg[2] ? {2'b00, ~cg[1]} : cg[1:0] + 3'h1))
        else $error("bad gain");
    sar_gap_a: assert property (sar_clk_en_o && seen && per != 5'h00
        |-> gap == {1'b0, per, 1'b1})
        else $error("bad tick spacing");
    full_rate_a: assert property (per == 5'h00 && !clk_gain_wr_i
        |=> sar_clk_en_o)
        else $error("tick missing");
endmodule // adcs_assertions
bind adcs_top adcs_assertions i_chk (.core_clk_i, .rst_b_i, .clk_gain_wr_i,
    .sfr_wdata_i, .mux_channel_select_o, .input_pair_config_o,
    .converter_clock_gain_config_o, .mux_pos_sel_o, .mux_neg_sel_o,
    .mux_diff_o, .mux_temp_o, .pga_gain_sel_o, .sar_clk_en_o);
`default_nettype wire

// ===== tb/adcs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_core_model (
    // Clock, reset and conversion tick.
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic sar_clk_en_i,
    // Cycles between the last two ticks.
    output logic [7:0] gap_o
);
    logic [7:0] cnt;
    // The core steps once per tick; it times how far apart they are.
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {cnt, gap_o} <= 16'h0000;
        end else begin
            cnt <= sar_clk_en_i ? 8'h00 : cnt + 8'h01;
            if (sar_clk_en_i) gap_o <= cnt + 8'h01;
        end
    end
endmodule // adcs_core_model
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk_i = 0, rst_b_i = 0;
    logic chan_sel_wr_i = 0, pair_cfg_wr_i = 0, clk_gain_wr_i = 0;
    logic [7:0] sfr_wdata_i = 8'h00;
    wire [7:0] mux_channel_select_o, input_pair_config_o, gap;
    wire [7:0] converter_clock_gain_config_o;
    wire [3:0] mux_pos_sel_o;
    wire [2:0] mux_neg_sel_o, pga_gain_sel_o;
    wire mux_diff_o, mux_temp_o, sar_clk_o, sar_clk_en_o, sar_rate_high_o;
    wire [7:0] steer = {mux_pos_sel_o, mux_neg_sel_o, mux_diff_o};
    int failures = 0, tests_run = 0;
    adcs_top i_dut (.core_clk_i, .rst_b_i, .chan_sel_wr_i, .pair_cfg_wr_i,
        .clk_gain_wr_i, .sfr_wdata_i, .mux_channel_select_o,
        .input_pair_config_o, .converter_clock_gain_config_o,
        .mux_pos_sel_o, .mux_neg_sel_o, .mux_diff_o, .mux_temp_o,
        .pga_gain_sel_o, .sar_clk_o, .sar_clk_en_o, .sar_rate_high_o);
    adcs_core_model i_core (.core_clk_i, .rst_b_i,
        .sar_clk_en_i(sar_clk_en_o), .gap_o(gap));
    initial forever #12.5 core_clk_i = ~core_clk_i;
    task automatic close_out;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Pulses the chosen strobes for one cycle, then lets outputs settle.
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge core_clk_i) #2;
        {chan_sel_wr_i, pair_cfg_wr_i, clk_gain_wr_i} = s;
        sfr_wdata_i = d;
        @(posedge core_clk_i) #2;
        {chan_sel_wr_i, pair_cfg_wr_i, clk_gain_wr_i} = 3'b000;
        @(posedge core_clk_i) #2;
    endtask
    task automatic t_reset;
        chk(mux_channel_select_o, 8'h00, "chan reset");
        chk(converter_clock_gain_config_o, 8'hF8, "cfg reset");
        chk({5'h0, pga_gain_sel_o}, 8'h01, "gain reset");
        $display("reset test done");
    endtask
    task automatic t_mux;
        logic [3:0] p;
        logic [7:0] e;
        for (int k = 0; k < 3; k++) begin
            p = (k == 0) ? 4'h0 : ((k == 1) ? 4'hF : 4'h5);
            wr(3'b010, {4'hC, p});
            chk(input_pair_config_o, {4'h0, p}, "pair read");
            for (int c = 0; c < 16; c++) begin
                wr(3'b100, {4'hA, c[3:0]});
                if (c[3]) e = 8'h80;
                else if (p[c[2:1]]) e = {1'b0, c[2:1], 1'b0, c[2:1], 2'b11};
                else e = {1'b0, c[2:0], 4'h0};
                chk(steer, e, "mux");
                chk({7'h0, mux_temp_o}, {7'h0, c[3]}, "temp");
                chk(mux_channel_select_o, {4'h0, c[3:0]}, "chan read");
            end
        end
        $display("mux test done");
    endtask
    task automatic t_gain;
        for (int g = 0; g < 8; g++) begin
            wr(3'b001, {5'h01, g[2:0]});
            chk(converter_clock_gain_config_o, {5'h01, g[2:0]}, "cfg");
            chk({5'h0, pga_gain_sel_o}, {5'h0, g[2] ? {2'b00, ~g[1]}
                : g[1:0] + 3'h1}, "gain");
        end
        $display("gain test done");
    endtask
    task automatic t_clk;
        int n[4] = '{0, 1, 7, 31};
        int k;
        int t;
        logic [7:0] eg;
        foreach (n[i]) begin
            wr(3'b001, {n[i][4:0], 3'h2});
            k = 3;
            t = 0;
            while (k > 0 && t < 1000) begin
                @(posedge core_clk_i) #2;
                t++;
                if (sar_clk_en_o === 1'b1) k--;
            end
            if (k > 0) begin
                // No tick in time: count it and go straight to the verdict.
                failures++;
                $display("[FAIL] %0t conversion tick missing", $time);
                return;
            end
            eg = (n[i] == 0) ? 8'h01 : 8'(2 * n[i] + 2);
            chk(gap, eg, "gap");
            chk({7'h0, sar_rate_high_o}, {7'h0, n[i] < 7}, "rate");
            // A tick marks the rise; the level then holds for N+1 cycles.
            if (n[i] > 0) begin
                chk({7'h0, sar_clk_o}, 8'h01, "sar rise");
                repeat (n[i]) @(posedge core_clk_i) #2;
                chk({7'h0, sar_clk_o}, 8'h01, "sar high");
                @(posedge core_clk_i) #2;
                chk({7'h0, sar_clk_o}, 8'h00, "sar fall");
            end
        end
        $display("clock test done");
    endtask
    initial begin
        repeat (20) @(posedge core_clk_i);
        #2 rst_b_i = 1'b1;
        t_reset();
        t_mux();
        t_gain();
        t_clk();
        close_out();
    end
    // Cuts a hang short.
    initial begin
        repeat (90000) @(posedge core_clk_i);
        failures++;
        close_out();
    end
endmodule // tb
`default_nettype wire
